/* rto_pkg.sv */
package rto_pkg;

  // Register offsets, clock-calendar side
  localparam logic [7:0] ADR_SEC    = 8'h00;
  localparam logic [7:0] ADR_MIN    = 8'h01;
  localparam logic [7:0] ADR_HOUR   = 8'h02;
  localparam logic [7:0] ADR_WDAY   = 8'h03;
  localparam logic [7:0] ADR_DAY    = 8'h04;
  localparam logic [7:0] ADR_MON    = 8'h05;
  localparam logic [7:0] ADR_YEAR   = 8'h06;
  localparam logic [7:0] ADR_TRIM   = 8'h07;
  localparam logic [7:0] ADR_ALM1   = 8'h08;
  localparam logic [7:0] ADR_ALM2   = 8'h10;
  localparam logic [7:0] ADR_OUTAGE = 8'h1B;

  // Register offsets, system clock side
  localparam logic [7:0] ADR_FLAG0  = 8'h20;
  localparam logic [7:0] ADR_MASK0  = 8'h24;
  localparam logic [7:0] ADR_STAT0  = 8'h28;
  localparam logic [7:0] ADR_SMASK0 = 8'h2A;
  localparam logic [7:0] LOCAL_LO   = 8'h20;
  localparam logic [7:0] LOCAL_HI   = 8'h2B;

  // Alarm field indices and control bits
  localparam logic [2:0] ALM_SEC  = 3'h0;
  localparam logic [2:0] ALM_MIN  = 3'h1;
  localparam logic [2:0] ALM_HOUR = 3'h2;
  localparam logic [2:0] ALM_DAY  = 3'h3;
  localparam logic [2:0] ALM_CTRL = 3'h4;
  localparam int ALM_EN_BIT  = 0;
  localparam int ALM_REP_BIT = 1;
  localparam int ALM_CMP_LSB = 2;

  // Outage control fields: enable and length in units of 2**OUT_UNIT_SH ticks
  localparam int OUT_EN_BIT  = 7;
  localparam int OUT_UNIT_SH = 8;

  // Interrupt flag registers and their timed-event bits
  localparam int FLG_SYS      = 0;
  localparam int FLG_CHG      = 1;
  localparam int FLG_TMR      = 2;
  localparam int FLG_WARN     = 3;
  localparam int SYS_MR_BIT   = 0;
  localparam int TMR_ALM1_BIT = 0;
  localparam int TMR_ALM2_BIT = 1;
  localparam int TMR_OUT_BIT  = 2;

  // Reset values
  localparam logic [7:0] RST_TIME = 8'h00;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;

  // Timing
  localparam int XTAL_HZ     = 32786;
  localparam int CLK_HZ      = 20_000_000;
  localparam int MR_HOLD_US  = 1000;
  localparam int MR_HOLD_CYC = MR_HOLD_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rto_req_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] year;
  } rto_time_t;

  typedef enum logic [1:0] {MR_IDLE, MR_DOWN, MR_UP, MR_REL} rto_mr_t;

endpackage

/* rto_alarm.sv */
`timescale 1ns/1ps
module rto_alarm (
  // Crystal clock and reset
  input  wire logic              xclk,
  input  wire logic              xrst_n,
  // Field access
  input  wire logic              wr_en,
  input  wire logic [2:0]        idx,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata,
  // Time base
  input  wire rto_pkg::rto_time_t now,
  input  wire logic              sec_tick,
  // Match event
  output logic                   fire_q
);
  logic [7:0] fld_q [5];
  logic       chk_q;
  logic [3:0] cmp;
  logic       match;

  // Disabled compare fields are don't-care, which gives periodic alarms
  assign cmp   = fld_q[rto_pkg::ALM_CTRL][rto_pkg::ALM_CMP_LSB +: 4];
  assign match = (!cmp[0] || fld_q[rto_pkg::ALM_SEC]  == now.sec)  &&
                 (!cmp[1] || fld_q[rto_pkg::ALM_MIN]  == now.min)  &&
                 (!cmp[2] || fld_q[rto_pkg::ALM_HOUR] == now.hour) &&
                 (!cmp[3] || fld_q[rto_pkg::ALM_DAY]  == now.day);
  assign rdata = (idx <= rto_pkg::ALM_CTRL) ? fld_q[idx] : 8'h00;

  // Compare one cycle after the tick, once the new time has settled
  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      chk_q  <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      chk_q  <= sec_tick;
      fire_q <= chk_q && fld_q[rto_pkg::ALM_CTRL][rto_pkg::ALM_EN_BIT] && match;
    end
  end

  // Fields; a one-shot alarm disarms itself, a host write in the same cycle wins
  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      for (int i = 0; i < 5; i++) begin
        fld_q[i] <= rto_pkg::RST_CTRL;
      end
    end else begin
      if (fire_q && !fld_q[rto_pkg::ALM_CTRL][rto_pkg::ALM_REP_BIT]) begin
        fld_q[rto_pkg::ALM_CTRL][rto_pkg::ALM_EN_BIT] <= 1'b0;
      end
      if (wr_en && idx <= rto_pkg::ALM_CTRL) begin
        fld_q[idx] <= wdata;
      end
    end
  end
endmodule

/* rto_top.sv */
`timescale 1ns/1ps
module rto_top #(
  parameter int XTAL_TICKS  = rto_pkg::XTAL_HZ,
  parameter int MR_HOLD_CYC = rto_pkg::MR_HOLD_CYC
) (
  // Clocks and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              xclk,
  // Register port of the serial interface
  input  wire logic              reg_valid,
  output logic                   reg_ready,
  input  wire rto_pkg::rto_req_t reg_req,
  output logic                   reg_done,
  output logic      [7:0]        reg_rdata,
  // Pins
  input  wire logic              supply_ok,
  input  wire logic              unit_working,
  input  wire logic              mreset_n,
  // Event and status sources, system clock
  input  wire logic      [7:0]   sys_evt,
  input  wire logic      [7:0]   chg_evt,
  input  wire logic      [7:0]   warn_evt,
  input  wire logic      [15:0]  stat_in,
  // Control outputs
  output logic                   irq_req,
  output logic                   power_up_req,
  output logic                   brief_outage_detect,
  output logic                   unit_power_down,
  output logic                   restore_defaults
);

  // ---------------- Crystal domain ----------------
  logic                xr1_q, xrst_n;
  logic [1:0]          xs1_q, xs2_q;
  logic                xrq3_q, x_edge, x_wr, req_tgl_q;
  logic                sup_prev_q;
  logic                x_ack_q;
  logic [7:0]          x_rd_q, x_rd_d;
  logic [2:0]          x_tgl_q;
  rto_pkg::rto_time_t  t_q;
  logic [7:0]          trim_q, outage_ctrl_q;
  logic [16:0]         pre_q, period;
  logic                sec_tick;
  logic [7:0]          alm_rd [2];
  logic [1:0]          alm_fire;
  logic                out_run_q;
  logic [14:0]         out_cnt_q, out_len;
  rto_pkg::rto_req_t   hold_q;

  // Reset release synchronised to the crystal clock
  always_ff @(posedge xclk or negedge arst_n) begin
    if (!arst_n) begin
      xr1_q  <= 1'b0;
      xrst_n <= 1'b0;
    end else begin
      xr1_q  <= 1'b1;
      xrst_n <= xr1_q;
    end
  end

  // Supply pin and request toggle into the crystal domain
  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      xs1_q  <= 2'h0;
      xs2_q  <= 2'h0;
      xrq3_q <= 1'b0;
    end else begin
      xs1_q  <= {req_tgl_q, supply_ok};
      xs2_q  <= xs1_q;
      xrq3_q <= xs2_q[1];
    end
  end
  assign x_edge = xs2_q[1] ^ xrq3_q;
  assign x_wr   = x_edge && hold_q.we;

  // BCD helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_inc = 8'(v + 8'h01);
    end
  endfunction

  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) begin
      month_end = leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      month_end = 8'h30;
    end else begin
      month_end = 8'h31;
    end
  endfunction

  // Day of week from the date, 0 = Sunday
  function automatic logic [7:0] week_day(input rto_pkg::rto_time_t t);
    int d, m, y, s;
    int tab [12];
    tab = '{0, 3, 2, 5, 0, 3, 5, 1, 4, 6, 2, 4};
    d = int'(t.day[7:4]) * 10 + int'(t.day[3:0]);
    m = int'(t.mon[7:4]) * 10 + int'(t.mon[3:0]);
    y = 2000 + int'(t.year[7:4]) * 10 + int'(t.year[3:0]);
    if (m < 3) begin
      y = y - 1;
    end
    if (m < 1 || m > 12) begin
      m = 1;
    end
    s = (y + y / 4 - y / 100 + y / 400 + tab[m - 1] + d) % 7;
    week_day = {5'h00, 3'(s)};
  endfunction

  // Prescaler; the first second of each minute is stretched or cut by trim
  assign period = (t_q.sec == 8'h00) ? 17'(XTAL_TICKS + int'($signed(trim_q)))
                                     : 17'(XTAL_TICKS);
  assign sec_tick = (pre_q >= 17'(period - 17'h00001));

  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      pre_q <= 17'h00000;
    end else if (x_wr && hold_q.addr == rto_pkg::ADR_SEC) begin
      pre_q <= 17'h00000; // Fresh full second after setting seconds
    end else if (sec_tick) begin
      pre_q <= 17'h00000;
    end else begin
      pre_q <= 17'(pre_q + 17'h00001);
    end
  end

  // Time and calendar; a host write overrides the tick for that field
  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      t_q.sec  <= rto_pkg::RST_TIME;
      t_q.min  <= rto_pkg::RST_TIME;
      t_q.hour <= rto_pkg::RST_TIME;
      t_q.day  <= rto_pkg::RST_DATE;
      t_q.mon  <= rto_pkg::RST_DATE;
      t_q.year <= rto_pkg::RST_YEAR;
    end else begin
      if (sec_tick) begin
        t_q.sec <= bcd_inc(t_q.sec);
        if (t_q.sec == 8'h59) begin
          t_q.sec <= 8'h00;
          t_q.min <= bcd_inc(t_q.min);
          if (t_q.min == 8'h59) begin
            t_q.min  <= 8'h00;
            t_q.hour <= bcd_inc(t_q.hour);
            if (t_q.hour == 8'h23) begin
              t_q.hour <= 8'h00;
              t_q.day  <= bcd_inc(t_q.day);
              if (t_q.day == month_end(t_q.mon, t_q.year)) begin
                t_q.day <= 8'h01;
                t_q.mon <= bcd_inc(t_q.mon);
                if (t_q.mon == 8'h12) begin
                  t_q.mon  <= 8'h01;
                  t_q.year <= (t_q.year == 8'h99) ? 8'h00 : bcd_inc(t_q.year);
                end
              end
            end
          end
        end
      end
      if (x_wr) begin
        case (hold_q.addr)
          rto_pkg::ADR_SEC:  t_q.sec  <= hold_q.wdata;
          rto_pkg::ADR_MIN:  t_q.min  <= hold_q.wdata;
          rto_pkg::ADR_HOUR: t_q.hour <= hold_q.wdata;
          rto_pkg::ADR_DAY:  t_q.day  <= hold_q.wdata;
          rto_pkg::ADR_MON:  t_q.mon  <= hold_q.wdata;
          rto_pkg::ADR_YEAR: t_q.year <= hold_q.wdata;
          default: ;
        endcase
      end
    end
  end

  // Two alarm units sharing the time base
  for (genvar k = 0; k < 2; k++) begin : g_alm
    localparam logic [7:0] BASE = (k == 0) ? rto_pkg::ADR_ALM1 : rto_pkg::ADR_ALM2;
    rto_alarm u_alarm (
      .xclk     (xclk),
      .xrst_n   (xrst_n),
      .wr_en    (x_wr && hold_q.addr[7:3] == BASE[7:3]),
      .idx      (hold_q.addr[2:0]),
      .wdata    (hold_q.wdata),
      .rdata    (alm_rd[k]),
      .now      (t_q),
      .sec_tick (sec_tick),
      .fire_q   (alm_fire[k])
    );
  end

  // Trim and outage control; the enable drops when power comes back
  assign out_len = {outage_ctrl_q[6:0], 8'h00};
  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      trim_q        <= rto_pkg::RST_CTRL;
      outage_ctrl_q <= rto_pkg::RST_CTRL;
    end else begin
      if (xs2_q[0] && !sup_prev_q) begin
        outage_ctrl_q[rto_pkg::OUT_EN_BIT] <= 1'b0;
      end
      if (x_wr && hold_q.addr == rto_pkg::ADR_TRIM) begin
        trim_q <= hold_q.wdata;
      end
      if (x_wr && hold_q.addr == rto_pkg::ADR_OUTAGE) begin
        outage_ctrl_q <= hold_q.wdata;
      end
    end
  end

  // Outage timer on crystal ticks
  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      sup_prev_q <= 1'b0;
      out_run_q  <= 1'b0;
      out_cnt_q  <= 15'h0000;
    end else begin
      sup_prev_q <= xs2_q[0];
      if (!xs2_q[0] && sup_prev_q && outage_ctrl_q[rto_pkg::OUT_EN_BIT]) begin
        out_run_q <= 1'b1;
        out_cnt_q <= 15'h0000;
      end else if (out_run_q && xs2_q[0]) begin
        out_run_q <= 1'b0;
      end else if (out_run_q) begin
        out_cnt_q <= 15'(out_cnt_q + 15'h0001);
        if (out_cnt_q >= out_len) begin
          out_run_q <= 1'b0;
        end
      end
    end
  end

  // Event toggles toward the system clock
  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      x_tgl_q <= 3'h0;
    end else begin
      x_tgl_q[0] <= x_tgl_q[0] ^ alm_fire[0];
      x_tgl_q[1] <= x_tgl_q[1] ^ alm_fire[1];
      x_tgl_q[2] <= x_tgl_q[2] ^ (out_run_q && xs2_q[0]);
    end
  end

  // Read mux for crystal-side registers
  always_comb begin
    x_rd_d = 8'h00;
    case (hold_q.addr)
      rto_pkg::ADR_SEC:    x_rd_d = t_q.sec;
      rto_pkg::ADR_MIN:    x_rd_d = t_q.min;
      rto_pkg::ADR_HOUR:   x_rd_d = t_q.hour;
      rto_pkg::ADR_WDAY:   x_rd_d = week_day(t_q);
      rto_pkg::ADR_DAY:    x_rd_d = t_q.day;
      rto_pkg::ADR_MON:    x_rd_d = t_q.mon;
      rto_pkg::ADR_YEAR:   x_rd_d = t_q.year;
      rto_pkg::ADR_TRIM:   x_rd_d = trim_q;
      rto_pkg::ADR_OUTAGE: x_rd_d = outage_ctrl_q;
      default: begin
        if (hold_q.addr[7:3] == rto_pkg::ADR_ALM1[7:3]) begin
          x_rd_d = alm_rd[0];
        end else if (hold_q.addr[7:3] == rto_pkg::ADR_ALM2[7:3]) begin
          x_rd_d = alm_rd[1];
        end
      end
    endcase
  end

  // Answer: data held until the next request, then ack toggles back
  always_ff @(posedge xclk or negedge xrst_n) begin
    if (!xrst_n) begin
      x_rd_q  <= 8'h00;
      x_ack_q <= 1'b0;
    end else if (x_edge) begin
      x_rd_q  <= x_rd_d;
      x_ack_q <= xs2_q[1];
    end
  end

  // ---------------- System clock domain ----------------
  logic [5:0]          in_s1_q, in_s2_q;
  logic [3:0]          tg_s3_q, tg_edge;
  logic                busy_q, acc, local_hit;
  logic [7:0]          loc_rd;
  logic [7:0]          interrupt_flag_regs_q [4];
  logic [7:0]          mask_q [4];
  logic [7:0]          smask_q [2];
  logic [7:0]          ev [4];
  logic                working, alm_wake, mr_done;
  rto_pkg::rto_mr_t    mr_q;
  logic [31:0]         mr_cnt_q;

  // Pins and crystal toggles, two flops before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_s1_q <= 6'h02;
      in_s2_q <= 6'h02;
      tg_s3_q <= 4'h0;
    end else begin
      in_s1_q <= {x_tgl_q, x_ack_q, mreset_n, unit_working};
      in_s2_q <= in_s1_q;
      tg_s3_q <= in_s2_q[5:2];
    end
  end
  assign tg_edge = in_s2_q[5:2] ^ tg_s3_q;
  assign working = in_s2_q[0];

  assign reg_ready = !busy_q;
  assign acc       = reg_valid && !busy_q;
  assign local_hit = reg_req.addr >= rto_pkg::LOCAL_LO && reg_req.addr <= rto_pkg::LOCAL_HI;

  // Crystal-side accesses hold the request and wait for the ack toggle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q    <= '0;
      req_tgl_q <= 1'b0;
      busy_q    <= 1'b0;
    end else if (acc && !local_hit) begin
      hold_q    <= reg_req;
      req_tgl_q <= !req_tgl_q;
      busy_q    <= 1'b1;
    end else if (tg_edge[0]) begin
      busy_q    <= 1'b0;
    end
  end

  // Local read mux; status is shown through its mask
  always_comb begin
    loc_rd = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (reg_req.addr == 8'(rto_pkg::ADR_FLAG0 + 8'(i))) begin
        loc_rd = interrupt_flag_regs_q[i];
      end
      if (reg_req.addr == 8'(rto_pkg::ADR_MASK0 + 8'(i))) begin
        loc_rd = mask_q[i];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (reg_req.addr == 8'(rto_pkg::ADR_STAT0 + 8'(i))) begin
        loc_rd = stat_in[8*i +: 8] & ~smask_q[i];
      end
      if (reg_req.addr == 8'(rto_pkg::ADR_SMASK0 + 8'(i))) begin
        loc_rd = smask_q[i];
      end
    end
  end

  // Answer on the port, one cycle for local registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_done  <= 1'b0;
      reg_rdata <= 8'h00;
    end else if (acc && local_hit) begin
      reg_done  <= 1'b1;
      reg_rdata <= reg_req.we ? 8'h00 : loc_rd;
    end else if (tg_edge[0]) begin
      reg_done  <= 1'b1;
      reg_rdata <= hold_q.we ? 8'h00 : x_rd_q;
    end else begin
      reg_done  <= 1'b0;
    end
  end

  // Event sources per flag register
  assign alm_wake = |tg_edge[2:1] && !working;
  assign ev[rto_pkg::FLG_SYS]  = sys_evt | (8'(mr_done) << rto_pkg::SYS_MR_BIT);
  assign ev[rto_pkg::FLG_CHG]  = chg_evt;
  assign ev[rto_pkg::FLG_TMR]  = ((8'(tg_edge[1] && working)) << rto_pkg::TMR_ALM1_BIT) |
                                 ((8'(tg_edge[2] && working)) << rto_pkg::TMR_ALM2_BIT) |
                                 ((8'(tg_edge[3])) << rto_pkg::TMR_OUT_BIT);
  assign ev[rto_pkg::FLG_WARN] = warn_evt;

  // Flags: masked sources never set; read clears, a new event wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        interrupt_flag_regs_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        interrupt_flag_regs_q[i] <= ((acc && !reg_req.we &&
            reg_req.addr == 8'(rto_pkg::ADR_FLAG0 + 8'(i))) ? 8'h00 :
            interrupt_flag_regs_q[i]) | (ev[i] & ~mask_q[i]);
      end
    end
  end

  // Mask registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        mask_q[i] <= rto_pkg::RST_MASK;
      end
      smask_q[0] <= rto_pkg::RST_MASK;
      smask_q[1] <= rto_pkg::RST_MASK;
    end else if (acc && reg_req.we) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_req.addr == 8'(rto_pkg::ADR_MASK0 + 8'(i))) begin
          mask_q[i] <= reg_req.wdata;
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (reg_req.addr == 8'(rto_pkg::ADR_SMASK0 + 8'(i))) begin
          smask_q[i] <= reg_req.wdata;
        end
      end
    end
  end

  // Master reset sequence; the pin must return high before rearming
  assign mr_done = (mr_q == rto_pkg::MR_UP);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mr_q     <= rto_pkg::MR_IDLE;
      mr_cnt_q <= 32'h00000000;
    end else begin
      unique case (mr_q)
        rto_pkg::MR_IDLE: begin
          mr_cnt_q <= 32'h00000000;
          if (!in_s2_q[1]) begin
            mr_q <= rto_pkg::MR_DOWN;
          end
        end
        rto_pkg::MR_DOWN: begin
          mr_cnt_q <= 32'(mr_cnt_q + 32'h00000001);
          if (mr_cnt_q >= 32'(MR_HOLD_CYC - 1)) begin
            mr_q <= rto_pkg::MR_UP;
          end
        end
        rto_pkg::MR_UP: mr_q <= rto_pkg::MR_REL;
        rto_pkg::MR_REL: begin
          if (in_s2_q[1]) begin
            mr_q <= rto_pkg::MR_IDLE;
          end
        end
      endcase
    end
  end

  // Registered control outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req             <= 1'b0;
      power_up_req        <= 1'b0;
      brief_outage_detect <= 1'b0;
      unit_power_down     <= 1'b0;
      restore_defaults    <= 1'b0;
    end else begin
      irq_req <= |(interrupt_flag_regs_q[0] & ~mask_q[0]) |
                 |(interrupt_flag_regs_q[1] & ~mask_q[1]) |
                 |(interrupt_flag_regs_q[2] & ~mask_q[2]) |
                 |(interrupt_flag_regs_q[3] & ~mask_q[3]);
      power_up_req        <= alm_wake || mr_done;
      brief_outage_detect <= tg_edge[3];
      unit_power_down     <= (mr_q == rto_pkg::MR_DOWN);
      restore_defaults    <= mr_done;
    end
  end

endmodule

/* rto_top_properties.sv */
`timescale 1ns/1ps
// Port checks of the housekeeping block
module rto_chk (
  // Clock and reset
  input wire logic              clk,
  input wire logic              arst_n,
  // Register port
  input wire logic              reg_valid,
  input wire logic              reg_ready,
  input wire rto_pkg::rto_req_t reg_req,
  input wire logic              reg_done,
  // Pins and events
  input wire logic              mreset_n,
  input wire logic              brief_outage_detect,
  input wire logic              unit_power_down,
  input wire logic              restore_defaults,
  input wire logic              power_up_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Answers on the register port
  local_ans_a:
  assert property (reg_valid && reg_ready && reg_req.addr >= rto_pkg::LOCAL_LO
    && reg_req.addr <= rto_pkg::LOCAL_HI |=> reg_done) else $error("local late");
  done_pulse_a:
  assert property (reg_done |=> !reg_done) else $error("done too long");
  done_ready_a:
  assert property (reg_done |-> reg_ready) else $error("ready not back");
  ready_ret_a:
  assert property ($fell(reg_ready) |-> ##[1:20] reg_done) else $error("no answer");
  // Outage and master reset
  brief_pulse_a:
  assert property (brief_outage_detect |=> !brief_outage_detect) else $error("outage pulse");
  mr_start_a:
  assert property ($fell(mreset_n) |-> ##[1:5] unit_power_down) else $error("no power down");
  down_hold_a:
  assert property ($rose(unit_power_down) |-> unit_power_down[*8]) else $error("hold short");
  down_end_a:
  assert property ($fell(unit_power_down) |-> ##[0:1] restore_defaults) else $error("no restore");
  restore_pair_a:
  assert property (restore_defaults |-> power_up_req && !unit_power_down) else $error("pair");
endmodule

bind rto_top rto_chk i_rto_chk (.*);

/* rto_host.sv */
`timescale 1ns/1ps
// Host side of the register port
module rto_host (
  // Clock
  input  wire logic              clk,
  // Register port
  output logic                   reg_valid,
  input  wire logic              reg_ready,
  output rto_pkg::rto_req_t      reg_req,
  input  wire logic              reg_done,
  input  wire logic [7:0]        reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_valid = 1'b0;
    reg_req = '0;
  end
  // Held until taken; scrambled once released so stale data is not trusted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output bit to);
    int n;
    n = 0;
    @(negedge clk);
    reg_req = '{we: w, addr: a, wdata: d};
    reg_valid = 1'b1;
    while (reg_ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    reg_valid = 1'b0;
    reg_req = ~reg_req;
    while (reg_done !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    rd = reg_rdata;
    to = (n >= 60);
  endtask
endmodule

/* test_rtc_alarm_outage_irq.sv */
`timescale 1ns/1ps
module test_rtc_alarm_outage_irq;
  logic clk, xclk, arst_n, supply_ok, unit_working, mreset_n, hit;
  logic reg_valid, reg_ready, reg_done, irq_req, power_up_req;
  logic brief_outage_detect, unit_power_down, restore_defaults;
  logic [7:0] reg_rdata, sys_evt, chg_evt, warn_evt, rd;
  logic [15:0] stat_in;
  rto_pkg::rto_req_t reg_req;
  int n_fail, comparisons;
  bit to;
  // Short second and hold keep the run brief
  rto_top #(.XTAL_TICKS(8), .MR_HOLD_CYC(10)) i_rto_top (.*);
  rto_host i_rto_host (.*);
  // Clocks, crystal unrelated in phase
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    xclk = 0;
    #7;
    forever #24 xclk = ~xclk;
  end
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_rto_host.xfer(w, a, d, rd, to);
    chk({7'h00, to}, 8'h00);
    if (to) give_verdict();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic await(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, s}, 8'h01);
    if (n >= lim) give_verdict();
  endtask
  task automatic t_reset();
    rdc(8'h04, 8'h01);
    rdc(8'h05, 8'h01);
    rdc(8'h1B, 8'h00);
    acc(1'b1, 8'h3F, 8'h5A);
    rdc(8'h3F, 8'h00);
    acc(1'b1, 8'h07, 8'hFE);
    rdc(8'h07, 8'hFE);
    acc(1'b1, 8'h07, 8'h00);
  endtask
  task automatic t_flags();
    acc(1'b1, 8'h27, 8'h10);
    sys_evt = 8'h04;
    chg_evt = 8'h08;
    warn_evt = 8'h10;
    @(negedge clk);
    {sys_evt, chg_evt, warn_evt} = '0;
    @(negedge clk);
    chk({7'h00, irq_req}, 8'h01);
    rdc(8'h20, 8'h04);
    rdc(8'h21, 8'h08);
    repeat (2) @(negedge clk);
    chk({7'h00, irq_req}, 8'h00);
    rdc(8'h23, 8'h00);
    acc(1'b1, 8'h2A, 8'h0F);
    rdc(8'h28, 8'h50);
    rdc(8'h29, 8'hA5);
  endtask
  // Last second of 28 February, common and leap year
  task automatic t_cal();
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 8'h06, i ? 8'h24 : 8'h23);
      acc(1'b1, 8'h05, 8'h02);
      acc(1'b1, 8'h04, 8'h28);
      acc(1'b1, 8'h02, 8'h23);
      acc(1'b1, 8'h01, 8'h59);
      acc(1'b1, 8'h00, 8'h59);
      repeat (30) @(negedge clk);
      rdc(8'h04, i ? 8'h29 : 8'h01);
      rdc(8'h05, i ? 8'h02 : 8'h03);
      rdc(8'h03, i ? 8'h04 : 8'h03);
      rdc(8'h02, 8'h00);
    end
  endtask
  task automatic t_alarm();
    // Seconds compare: must stay quiet until the seconds field matches
    acc(1'b1, 8'h08, 8'h05);
    acc(1'b1, 8'h0C, 8'h05);
    repeat (30) @(negedge clk);
    chk({7'h00, irq_req}, 8'h00);
    acc(1'b1, 8'h00, 8'h03);
    await(irq_req, 60);
    rdc(8'h22, 8'h01);
    rdc(8'h0C, 8'h04);
    unit_working = 0;
    acc(1'b1, 8'h14, 8'h03);
    await(power_up_req, 60);
    @(negedge clk);
    await(power_up_req, 60);
    rdc(8'h22, 8'h00);
    acc(1'b1, 8'h26, 8'h02);
    unit_working = 1;
    repeat (30) @(negedge clk);
    chk({7'h00, irq_req}, 8'h00);
    acc(1'b1, 8'h14, 8'h00);
    acc(1'b0, 8'h22, 8'h00);
    acc(1'b1, 8'h26, 8'h00);
  endtask
  // Short drop is reported, one past the timer is not
  task automatic t_outage();
    acc(1'b1, 8'h1B, 8'h81);
    supply_ok = 0;
    repeat (20) @(negedge clk);
    supply_ok = 1;
    await(brief_outage_detect, 40);
    rdc(8'h22, 8'h04);
    rdc(8'h1B, 8'h01);
    acc(1'b1, 8'h1B, 8'h81);
    supply_ok = 0;
    repeat (300) @(negedge clk);
    supply_ok = 1;
    hit = 0;
    repeat (40) begin
      @(negedge clk);
      if (brief_outage_detect === 1'b1) hit = 1;
    end
    chk({7'h00, hit}, 8'h00);
  endtask
  task automatic t_mreset();
    mreset_n = 0;
    repeat (5) @(negedge clk);
    chk({7'h00, unit_power_down}, 8'h01);
    mreset_n = 1;
    await(restore_defaults, 30);
    chk({7'h00, unit_power_down}, 8'h00);
    rdc(8'h20, 8'h01);
  endtask
  // Main sequence
  initial begin
    {arst_n, sys_evt, chg_evt, warn_evt, n_fail, comparisons} = '0;
    {supply_ok, unit_working, mreset_n} = 3'h7;
    stat_in = 16'hA55A;
    repeat (12) @(negedge clk);
    arst_n = 1;
    repeat (10) @(negedge clk);
    t_reset();
    t_flags();
    t_cal();
    t_alarm();
    t_outage();
    t_mreset();
    give_verdict();
  end
endmodule
